// *** include/conv_regs_pkg.sv ***
/*
  Constants for the converter status and configuration register bank:
  register offsets, reset values, writable-bit masks, field positions and
  the discharge sequencer states.
  Assumes a byte-wide register port with 8-bit offsets.
*/
`default_nettype none

package conv_regs_pkg;

  // register offsets
  localparam logic [7:0] OFF_FAULT_STATUS = 8'h78;
  localparam logic [7:0] OFF_POWER_PATH = 8'h81;
  localparam logic [7:0] OFF_CONFIG_ZERO = 8'hD0;
  localparam logic [7:0] OFF_CONFIG_ONE = 8'hD1;
  localparam logic [7:0] OFF_SCALING_DISCH = 8'hD2;
  localparam logic [7:0] OFF_INPUT_PROT = 8'hD3;

  // values after reset
  localparam logic [7:0] RST_FAULT_STATUS = 8'h00;
  localparam logic [7:0] RST_POWER_PATH = 8'h01;
  localparam logic [7:0] RST_CONFIG_ZERO = 8'h32;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h09;
  localparam logic [7:0] RST_SCALING_DISCH = 8'h40;
  localparam logic [7:0] RST_INPUT_PROT = 8'h20;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // implemented bits; all others are dropped on write and read as zero
  localparam logic [7:0] MASK_POWER_PATH = 8'h03;
  localparam logic [7:0] MASK_CONFIG_ZERO = 8'h7F;
  localparam logic [7:0] MASK_CONFIG_ONE = 8'hFF;
  localparam logic [7:0] MASK_SCALING_DISCH = 8'h7F;
  localparam logic [7:0] MASK_INPUT_PROT = 8'hFF;

  // status summary bit positions
  localparam int STS_BUSY = 7;
  localparam int STS_OFF = 6;
  localparam int STS_OVERVOLT = 5;
  localparam int STS_OVERCURR = 4;
  localparam int STS_UNDERVOLT = 3;
  localparam int STS_TEMPERATURE = 2;
  localparam int STS_COMM_LOGIC_MEM = 1;
  localparam int STS_OTHER = 0;

  // power path control fields
  localparam int PP_FORCE_DISCHARGE = 1;
  localparam int PP_STAGE_ENABLE_ALT = 0;

  // configuration zero fields
  localparam int C0_NEG_LIMIT = 6;
  localparam int C0_AUX_REGULATOR = 5;
  localparam int C0_MONITOR_LIMITER = 4;
  localparam int C0_HICCUP = 3;
  localparam int C0_DUAL_SPREAD = 2;
  localparam int C0_MICRO_SLEEP = 1;
  localparam int C0_STAGE_ENABLE = 0;

  // configuration one fields
  localparam int C1_THERMAL_WARN = 7;
  localparam int C1_WARN_LEVEL_HI = 6;
  localparam int C1_WARN_LEVEL_LO = 5;
  localparam int C1_FAULT_PIN_INT = 4;
  localparam int C1_TRACK_DIRECT = 3;
  localparam int C1_AUX_PIN_PRIO = 2;
  localparam int C1_TWO_PHASE_FORCED_PWM = 1;
  localparam int C1_TWO_PHASE_POWER_SAVE = 0;

  // scaling and discharge fields
  localparam int SD_ACTIVE_DOWN_RAMP = 6;
  localparam int SD_SLEW_HI = 5;
  localparam int SD_SLEW_LO = 4;
  localparam int SD_DISCH_CUR_HI = 3;
  localparam int SD_DISCH_CUR_LO = 2;
  localparam int SD_DISCH_WITH_EN = 1;
  localparam int SD_DISCH_TO_THRESH = 0;

  // discharge current levels seen by the analog side
  localparam logic [1:0] DISCH_LEVEL_25MA = 2'h0;
  localparam logic [1:0] DISCH_LEVEL_50MA = 2'h1;
  localparam logic [1:0] DISCH_LEVEL_75MA = 2'h2;

  typedef enum logic [1:0] {
    DIS_IDLE = 2'b01,
    DIS_ACTIVE = 2'b10
  } discharge_state_type;

endpackage : conv_regs_pkg

`default_nettype wire

// *** hw/converter_status_config_regs.sv ***
/*
  Byte-wide status and configuration register bank of a four-switch
  buck-boost controller, with the small amount of logic that the fields
  steer directly: power-stage run qualification, the status summary and
  the output discharge sequencer.
  Assumes the serial protocol engine presents single-cycle read and write
  strobes with an 8-bit offset, and that condition inputs are synchronous
  to REF_CLK_I.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - status bit 7 shows busy; bit 6 shows unit off or no output.
// - status bits 5, 4, 3 show overvoltage, overcurrent, input undervoltage.
// - status bits 2, 1, 0 show temperature, comm/logic/memory, other faults.
// - status summary at 0x78 is read-only; from reset bit 6 (off) reads one.
// - unimplemented bits ignore writes and always read zero.
// - 0x81 bit 1 forces output discharge; resets disabled.
// - 0x81 bit 0 stage enable resets 1; 0xD0 bit 0 enable resets 0.
// - 0xD0 bit 6 extends current limit to negative inductor current.
// - 0xD0 bit 5 enables the auxiliary regulator; resets enabled.
// - 0xD0 bit 4 puts current monitor in limiter mode; resets enabled.
// - 0xD0 bit 3 enables hiccup short-circuit protection; resets disabled.
// - 0xD0 bit 2 dual spread spectrum resets 0; bit 1 micro-sleep resets 1.
// - 0xD1 bit 7 thermal warning enable; bits 6:5 pick 140/125/110/95 C.
// - 0xD1 bit 4 selects interrupt or fault behaviour of fault pin.
// - 0xD1 bit 3 lets tracking start without waiting for its signal.
// - 0xD1 bit 2 favours aux supply pin for second internal rail.
// - 0xD1 bit 1 two-phase in forced PWM; bit 0 in power save.
// - 0xD2 bit 6 enables active down ramp via discharge path.
// - 0xD2 bits 5:4 pick slew 40, 20, 1, 0.5 mV/us.
// - 0xD2 bits 3:2 pick discharge 25, 50, 75, 75 mA.
// - 0xD2 bit 1 ties output discharge to power-stage enable.
// - 0xD2 bit 0 keeps discharge on until threshold voltage reached.
module converter_status_config_regs (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic BUSY_I,
  input wire logic OUTPUT_GOOD_I,
  input wire logic OUTPUT_OVERVOLTAGE_I,
  input wire logic OUTPUT_OVERCURRENT_I,
  input wire logic INPUT_UNDERVOLTAGE_I,
  input wire logic TEMP_FAULT_I,
  input wire logic [3:0] TEMP_ABOVE_LEVEL_I,
  input wire logic COMM_LOGIC_MEMORY_I,
  input wire logic OTHER_FAULT_I,
  input wire logic SCALING_DOWN_I,
  input wire logic AT_DISCH_THRESHOLD_I,
  output logic POWER_STAGE_RUN_O,
  output logic DISCHARGE_ACTIVE_O,
  output logic [1:0] DISCHARGE_LEVEL_O,
  output logic THERMAL_WARNING_O,
  output logic NEG_LIMIT_ENABLE_O,
  output logic AUX_REGULATOR_ENABLE_O,
  output logic MONITOR_LIMITER_ENABLE_O,
  output logic HICCUP_ENABLE_O,
  output logic DUAL_SPREAD_ENABLE_O,
  output logic MICRO_SLEEP_ENABLE_O,
  output logic FAULT_PIN_INTERRUPT_SELECT_O,
  output logic TRACKING_DIRECT_STARTUP_O,
  output logic AUX_SUPPLY_PIN_PRIORITY_O,
  output logic TWO_PHASE_FORCED_PWM_ENABLE_O,
  output logic TWO_PHASE_POWER_SAVE_ENABLE_O,
  output logic [1:0] SCALING_SLEW_SELECT_O,
  output logic [7:0] INPUT_PROT_CONFIG_O
);

  logic [7:0] power_path_ff;
  logic [7:0] config_zero_ff;
  logic [7:0] config_one_ff;
  logic [7:0] scaling_disch_ff;
  logic [7:0] input_prot_ff;
  logic [7:0] status_now;
  logic run_ff;
  logic nxt_run;
  logic run_prev_ff;
  logic disch_on_ff;
  logic [1:0] disch_level_ff;
  logic thermal_warn_ff;
  logic nxt_thermal_warn;
  logic disch_hold;
  logic disch_start;
  logic disch_leave;
  conv_regs_pkg::discharge_state_type disch_state_ff;
  conv_regs_pkg::discharge_state_type nxt_disch_state;

  // masked write value; dropped bits can never reach storage
  function automatic logic [7:0] masked_write(input logic [7:0] data, input logic [7:0] mask);
    masked_write = data & mask;
  endfunction : masked_write

  function automatic logic [1:0] disch_level(input logic [1:0] code);
    case (code)
      2'h0: disch_level = conv_regs_pkg::DISCH_LEVEL_25MA;
      2'h1: disch_level = conv_regs_pkg::DISCH_LEVEL_50MA;
      default: disch_level = conv_regs_pkg::DISCH_LEVEL_75MA;
    endcase
  endfunction : disch_level

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      power_path_ff <= conv_regs_pkg::RST_POWER_PATH;
    end else if (REG_WR_I && REG_ADDR_I == conv_regs_pkg::OFF_POWER_PATH) begin
      power_path_ff <= masked_write(REG_WDATA_I, conv_regs_pkg::MASK_POWER_PATH);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      config_zero_ff <= conv_regs_pkg::RST_CONFIG_ZERO;
    end else if (REG_WR_I && REG_ADDR_I == conv_regs_pkg::OFF_CONFIG_ZERO) begin
      config_zero_ff <= masked_write(REG_WDATA_I, conv_regs_pkg::MASK_CONFIG_ZERO);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      config_one_ff <= conv_regs_pkg::RST_CONFIG_ONE;
    end else if (REG_WR_I && REG_ADDR_I == conv_regs_pkg::OFF_CONFIG_ONE) begin
      config_one_ff <= masked_write(REG_WDATA_I, conv_regs_pkg::MASK_CONFIG_ONE);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scaling_disch_ff <= conv_regs_pkg::RST_SCALING_DISCH;
    end else if (REG_WR_I && REG_ADDR_I == conv_regs_pkg::OFF_SCALING_DISCH) begin
      scaling_disch_ff <= masked_write(REG_WDATA_I, conv_regs_pkg::MASK_SCALING_DISCH);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      input_prot_ff <= conv_regs_pkg::RST_INPUT_PROT;
    end else if (REG_WR_I && REG_ADDR_I == conv_regs_pkg::OFF_INPUT_PROT) begin
      input_prot_ff <= masked_write(REG_WDATA_I, conv_regs_pkg::MASK_INPUT_PROT);
    end
  end

  assign nxt_run = power_path_ff[conv_regs_pkg::PP_STAGE_ENABLE_ALT] &
                   config_zero_ff[conv_regs_pkg::C0_STAGE_ENABLE];

  // warning compares against the selected level only
  assign nxt_thermal_warn = config_one_ff[conv_regs_pkg::C1_THERMAL_WARN] &
                            TEMP_ABOVE_LEVEL_I[config_one_ff[conv_regs_pkg::C1_WARN_LEVEL_HI:
                                                             conv_regs_pkg::C1_WARN_LEVEL_LO]];

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_ff <= 1'b0;
      run_prev_ff <= 1'b0;
      thermal_warn_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      run_prev_ff <= run_ff;
      thermal_warn_ff <= nxt_thermal_warn;
    end
  end

  // busy and off from live state
  always_comb begin
    status_now = conv_regs_pkg::RST_FAULT_STATUS;
    status_now[conv_regs_pkg::STS_BUSY] = BUSY_I;
    status_now[conv_regs_pkg::STS_OFF] = ~(run_ff & OUTPUT_GOOD_I);
    status_now[conv_regs_pkg::STS_OVERVOLT] = OUTPUT_OVERVOLTAGE_I;
    status_now[conv_regs_pkg::STS_OVERCURR] = OUTPUT_OVERCURRENT_I;
    status_now[conv_regs_pkg::STS_UNDERVOLT] = INPUT_UNDERVOLTAGE_I;
    status_now[conv_regs_pkg::STS_TEMPERATURE] = TEMP_FAULT_I | thermal_warn_ff;
    status_now[conv_regs_pkg::STS_COMM_LOGIC_MEM] = COMM_LOGIC_MEMORY_I;
    status_now[conv_regs_pkg::STS_OTHER] = OTHER_FAULT_I;
  end

  // status has no write path; unmapped reads zero
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= conv_regs_pkg::RST_READ_DATA;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        if (REG_ADDR_I == conv_regs_pkg::OFF_FAULT_STATUS) begin
          REG_RDATA_O <= status_now;
        end else if (REG_ADDR_I == conv_regs_pkg::OFF_POWER_PATH) begin
          REG_RDATA_O <= power_path_ff;
        end else if (REG_ADDR_I == conv_regs_pkg::OFF_CONFIG_ZERO) begin
          REG_RDATA_O <= config_zero_ff;
        end else if (REG_ADDR_I == conv_regs_pkg::OFF_CONFIG_ONE) begin
          REG_RDATA_O <= config_one_ff;
        end else if (REG_ADDR_I == conv_regs_pkg::OFF_SCALING_DISCH) begin
          REG_RDATA_O <= scaling_disch_ff;
        end else if (REG_ADDR_I == conv_regs_pkg::OFF_INPUT_PROT) begin
          REG_RDATA_O <= input_prot_ff;
        end else begin
          REG_RDATA_O <= conv_regs_pkg::RST_READ_DATA;
        end
      end
    end
  end

  // discharge sources: forced, scaling down, or stage switched off
  // hold: any of the three sources still requesting discharge
  assign disch_hold = power_path_ff[conv_regs_pkg::PP_FORCE_DISCHARGE] |
                      (scaling_disch_ff[conv_regs_pkg::SD_ACTIVE_DOWN_RAMP] & SCALING_DOWN_I) |
                      (scaling_disch_ff[conv_regs_pkg::SD_DISCH_WITH_EN] & ~run_ff);
  // edge on turn-off, so a finished threshold discharge does not restart
  assign disch_start = power_path_ff[conv_regs_pkg::PP_FORCE_DISCHARGE] |
                       (scaling_disch_ff[conv_regs_pkg::SD_ACTIVE_DOWN_RAMP] & SCALING_DOWN_I) |
                       (scaling_disch_ff[conv_regs_pkg::SD_DISCH_WITH_EN] & run_prev_ff & ~run_ff);
  // hold on until threshold when selected
  assign disch_leave = scaling_disch_ff[conv_regs_pkg::SD_DISCH_TO_THRESH] ?
                       (AT_DISCH_THRESHOLD_I & ~power_path_ff[conv_regs_pkg::PP_FORCE_DISCHARGE]) :
                       ~disch_hold;

  always_comb begin
    nxt_disch_state = disch_state_ff;
    case (disch_state_ff)
      conv_regs_pkg::DIS_IDLE: begin
        if (disch_start) begin
          nxt_disch_state = conv_regs_pkg::DIS_ACTIVE;
        end
      end
      conv_regs_pkg::DIS_ACTIVE: begin
        if (disch_leave) begin
          nxt_disch_state = conv_regs_pkg::DIS_IDLE;
        end
      end
      default: begin
        nxt_disch_state = conv_regs_pkg::DIS_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      disch_state_ff <= conv_regs_pkg::DIS_IDLE;
      disch_on_ff <= 1'b0;
      disch_level_ff <= conv_regs_pkg::DISCH_LEVEL_25MA;
    end else begin
      disch_state_ff <= nxt_disch_state;
      disch_on_ff <= (nxt_disch_state == conv_regs_pkg::DIS_ACTIVE);
      disch_level_ff <= disch_level(scaling_disch_ff[conv_regs_pkg::SD_DISCH_CUR_HI:
                                                     conv_regs_pkg::SD_DISCH_CUR_LO]);
    end
  end

  assign POWER_STAGE_RUN_O = run_ff;
  assign DISCHARGE_ACTIVE_O = disch_on_ff;
  assign DISCHARGE_LEVEL_O = disch_level_ff;
  assign THERMAL_WARNING_O = thermal_warn_ff;
  assign NEG_LIMIT_ENABLE_O = config_zero_ff[conv_regs_pkg::C0_NEG_LIMIT];
  assign AUX_REGULATOR_ENABLE_O = config_zero_ff[conv_regs_pkg::C0_AUX_REGULATOR];
  assign MONITOR_LIMITER_ENABLE_O = config_zero_ff[conv_regs_pkg::C0_MONITOR_LIMITER];
  assign HICCUP_ENABLE_O = config_zero_ff[conv_regs_pkg::C0_HICCUP];
  assign DUAL_SPREAD_ENABLE_O = config_zero_ff[conv_regs_pkg::C0_DUAL_SPREAD];
  assign MICRO_SLEEP_ENABLE_O = config_zero_ff[conv_regs_pkg::C0_MICRO_SLEEP];
  assign FAULT_PIN_INTERRUPT_SELECT_O = config_one_ff[conv_regs_pkg::C1_FAULT_PIN_INT];
  assign TRACKING_DIRECT_STARTUP_O = config_one_ff[conv_regs_pkg::C1_TRACK_DIRECT];
  assign AUX_SUPPLY_PIN_PRIORITY_O = config_one_ff[conv_regs_pkg::C1_AUX_PIN_PRIO];
  assign TWO_PHASE_FORCED_PWM_ENABLE_O = config_one_ff[conv_regs_pkg::C1_TWO_PHASE_FORCED_PWM];
  assign TWO_PHASE_POWER_SAVE_ENABLE_O = config_one_ff[conv_regs_pkg::C1_TWO_PHASE_POWER_SAVE];
  assign SCALING_SLEW_SELECT_O = scaling_disch_ff[conv_regs_pkg::SD_SLEW_HI:conv_regs_pkg::SD_SLEW_LO];
  assign INPUT_PROT_CONFIG_O = input_prot_ff;

endmodule : converter_status_config_regs

`default_nettype wire

// *** include/README_unused.sv ***
`default_nettype none
`default_nettype wire

// *** tb/conv_regs_asserts.sv ***
/*
  Port-level checker for the converter status and configuration bank.
  Assumes one clock domain and single-cycle register strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_regs_asserts (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic BUSY_I,
  input wire logic OUTPUT_OVERVOLTAGE_I,
  input wire logic OUTPUT_OVERCURRENT_I,
  input wire logic INPUT_UNDERVOLTAGE_I,
  input wire logic POWER_STAGE_RUN_O,
  input wire logic DISCHARGE_ACTIVE_O,
  input wire logic [1:0] DISCHARGE_LEVEL_O,
  input wire logic HICCUP_ENABLE_O,
  input wire logic TWO_PHASE_POWER_SAVE_ENABLE_O,
  input wire logic [1:0] SCALING_SLEW_SELECT_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  sequence rd_of(a);
    REG_RD_I && REG_ADDR_I == a;
  endsequence
  sequence wr_of(a);
    REG_WR_I && REG_ADDR_I == a;
  endsequence
  sequence force_wr;
    wr_of(8'h81) ##0 REG_WDATA_I[1];
  endsequence
  a_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read without valid");
  a_no_stray_valid: assert property (!REG_RD_I |=> !REG_RVALID_O)
    else $error("valid without read");
  a_status_busy: assert property (rd_of(8'h78) |=> REG_RDATA_O[7] == $past(BUSY_I))
    else $error("busy bit wrong");
  a_status_off: assert property (rd_of(8'h78) ##0 !POWER_STAGE_RUN_O |=> REG_RDATA_O[6])
    else $error("off bit clear while stopped");
  a_status_faults: assert property (rd_of(8'h78) |=> REG_RDATA_O[5:3] ==
    $past({OUTPUT_OVERVOLTAGE_I, OUTPUT_OVERCURRENT_I, INPUT_UNDERVOLTAGE_I}))
    else $error("fault bits wrong");
  a_unused_zero: assert property (rd_of(8'h81) |=> REG_RDATA_O[7:2] == 6'h00)
    else $error("unused bits not zero");
  a_hiccup_write: assert property (wr_of(8'hD0) |=> HICCUP_ENABLE_O == $past(REG_WDATA_I[3]))
    else $error("hiccup field not written");
  a_hiccup_hold: assert property (!REG_WR_I |=> $stable(HICCUP_ENABLE_O))
    else $error("hiccup field moved");
  a_save_phase_write: assert property (wr_of(8'hD1) |=> TWO_PHASE_POWER_SAVE_ENABLE_O == $past(REG_WDATA_I[0]))
    else $error("power save two-phase field not written");
  a_slew_write: assert property (wr_of(8'hD2) |=> SCALING_SLEW_SELECT_O == $past(REG_WDATA_I[5:4]))
    else $error("slew field not written");
  a_disch_level: assert property (DISCHARGE_LEVEL_O != 2'h3)
    else $error("discharge level code 3");
  a_force_discharge: assert property (force_wr |-> ##2 DISCHARGE_ACTIVE_O)
    else $error("forced discharge late");
endmodule : conv_regs_asserts

bind converter_status_config_regs conv_regs_asserts chk_u (.REF_CLK_I, .RST_I, .REG_ADDR_I, .REG_WR_I,
  .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .BUSY_I, .OUTPUT_OVERVOLTAGE_I,
  .OUTPUT_OVERCURRENT_I, .INPUT_UNDERVOLTAGE_I, .POWER_STAGE_RUN_O, .DISCHARGE_ACTIVE_O,
  .DISCHARGE_LEVEL_O, .HICCUP_ENABLE_O, .TWO_PHASE_POWER_SAVE_ENABLE_O, .SCALING_SLEW_SELECT_O);
`default_nettype wire

// *** tb/mgmt_host_model.sv ***
/*
  Management bus host: issues one-byte register writes and reads.
  Assumes the bank answers a read with valid data one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // released lines show inverted values so stale data is never trusted
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask : rd_reg
endmodule : mgmt_host_model
`default_nettype wire

// *** tb/converter_status_config_regs_tb_top.sv ***
/*
  Self-checking bench for the converter status and configuration bank.
  Assumes the host model's one-cycle read answer and live status inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module converter_status_config_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cond = 8'h00;
  logic [3:0] temp_lvl = 4'h0;
  logic scal_dn = 1'b0;
  logic at_thr = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd;
  logic run, dis, warn;
  logic [1:0] lvl, slew;
  wire logic [5:0] c0f;
  wire logic [4:0] c1f;
  logic [7:0] prot;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] offs [5] = '{8'h81, 8'hD0, 8'hD1, 8'hD2, 8'hD3};
  logic [7:0] rv [5] = '{8'h01, 8'h32, 8'h09, 8'h40, 8'h20};
  logic [7:0] mk [5] = '{8'h03, 8'h7F, 8'hFF, 8'h7F, 8'hFF};
  logic rvalid;
  always #2.5 clk = ~clk;
  mgmt_host_model host_u (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
    .rdata_i(rdata), .rvalid_i(rvalid));
  converter_status_config_regs dut_u (.REF_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .BUSY_I(cond[7]), .OUTPUT_GOOD_I(~cond[6]), .OUTPUT_OVERVOLTAGE_I(cond[5]),
    .OUTPUT_OVERCURRENT_I(cond[4]), .INPUT_UNDERVOLTAGE_I(cond[3]), .TEMP_FAULT_I(cond[2]),
    .TEMP_ABOVE_LEVEL_I(temp_lvl), .COMM_LOGIC_MEMORY_I(cond[1]), .OTHER_FAULT_I(cond[0]),
    .SCALING_DOWN_I(scal_dn), .AT_DISCH_THRESHOLD_I(at_thr), .POWER_STAGE_RUN_O(run),
    .DISCHARGE_ACTIVE_O(dis), .DISCHARGE_LEVEL_O(lvl), .THERMAL_WARNING_O(warn),
    .NEG_LIMIT_ENABLE_O(c0f[5]), .AUX_REGULATOR_ENABLE_O(c0f[4]), .MONITOR_LIMITER_ENABLE_O(c0f[3]),
    .HICCUP_ENABLE_O(c0f[2]), .DUAL_SPREAD_ENABLE_O(c0f[1]), .MICRO_SLEEP_ENABLE_O(c0f[0]),
    .FAULT_PIN_INTERRUPT_SELECT_O(c1f[4]), .TRACKING_DIRECT_STARTUP_O(c1f[3]),
    .AUX_SUPPLY_PIN_PRIORITY_O(c1f[2]), .TWO_PHASE_FORCED_PWM_ENABLE_O(c1f[1]),
    .TWO_PHASE_POWER_SAVE_ENABLE_O(c1f[0]), .SCALING_SLEW_SELECT_O(slew), .INPUT_PROT_CONFIG_O(prot));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // hang guard at 20000 cycles: the full sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  // outputs are looked at only after they have had time to settle
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check({2'h0, c0f}, 8'h19);
    check({3'h0, c1f}, 8'h09);
    check({6'h0, slew}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      host_u.rd_reg(offs[i], d);
      check(d, rv[i]);
      host_u.wr_reg(offs[i], 8'hFF);
      host_u.rd_reg(offs[i], d);
      check(d, mk[i]);
    end
    check({2'h0, c0f}, 8'h3F);
    check({3'h0, c1f}, 8'h1F);
    check(prot, 8'hFF);
    host_u.rd_reg(8'h00, d);
    check(d, 8'h00);
    host_u.wr_reg(8'h81, 8'h01);
    host_u.wr_reg(8'hD0, 8'h01);
    host_u.wr_reg(8'hD1, 8'h00);
    host_u.wr_reg(8'hD2, 8'h00);
    host_u.wr_reg(8'h78, 8'hFF);
    repeat (4) @(posedge clk);
    check({7'h0, run}, 8'h01);
    for (int k = 0; k < 8; k++) begin
      cond <= 8'h01 << k;
      host_u.rd_reg(8'h78, d);
      check(d, 8'h01 << k);
    end
    cond <= 8'h00;
    host_u.rd_reg(8'h78, d);
    check(d, 8'h00);
    host_u.wr_reg(8'h81, 8'h03);
    repeat (2) @(posedge clk);
    check({7'h0, dis}, 8'h01);
    host_u.wr_reg(8'h81, 8'h01);
    settle();
    check({7'h0, dis}, 8'h00);
    host_u.wr_reg(8'hD2, 8'h02);
    host_u.wr_reg(8'h81, 8'h00);
    settle();
    check({6'h0, run, dis}, 8'h01);
    // stage stopped: the off bit must show
    host_u.rd_reg(8'h78, d);
    check(d, 8'h40);
    host_u.wr_reg(8'h81, 8'h01);
    settle();
    check({6'h0, run, dis}, 8'h02);
    host_u.wr_reg(8'hD2, 8'h40);
    scal_dn <= 1'b1;
    settle();
    check({7'h0, dis}, 8'h01);
    scal_dn <= 1'b0;
    settle();
    check({7'h0, dis}, 8'h00);
    host_u.wr_reg(8'hD2, 8'h01);
    host_u.wr_reg(8'h81, 8'h03);
    host_u.wr_reg(8'h81, 8'h01);
    settle();
    check({7'h0, dis}, 8'h01);
    at_thr <= 1'b1;
    settle();
    check({7'h0, dis}, 8'h00);
    for (int c = 0; c < 4; c++) begin
      host_u.wr_reg(8'hD2, 8'(c << 2));
      settle();
      check({6'h0, lvl}, (c == 3) ? 8'h02 : 8'(c));
      temp_lvl <= 4'h1 << c;
      host_u.wr_reg(8'hD1, 8'(8'h80 | (c << 5)));
      settle();
      check({7'h0, warn}, 8'h01);
      temp_lvl <= ~(4'h1 << c);
      settle();
      check({7'h0, warn}, 8'h00);
    end
    close_out();
  end
endmodule : converter_status_config_regs_tb_top
`default_nettype wire
